// ---- inc/parallel_slave_byte_port_cfg.svh ----
`ifndef PARALLEL_SLAVE_BYTE_PORT_CFG_SVH
`define PARALLEL_SLAVE_BYTE_PORT_CFG_SVH

// ------------------------------------------------------------
// Bus widths
// ------------------------------------------------------------
`define AXI_ADDR_W        12
`define AXI_DATA_W        32

// ------------------------------------------------------------
// Register indexes, byte address is four times the index
// ------------------------------------------------------------
`define DATA_PORT_IDX     8'h08
`define STROBE_PORT_IDX   8'h09
`define IRQ_FLAGS_IDX     8'h0C
`define DATA_DIR_IDX      8'h88
`define CTRL_STATUS_IDX   8'h89
`define IRQ_ENABLES_IDX   8'h8C
`define UNMAPPED_IDX      8'hFF

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define IBF_BIT           7
`define OBF_BIT           6
`define INPUT_OVERFLOW_FLAG_BIT          5
`define MODE_BIT          4
`define SLAVE_IRQ_BIT     7
`define RD_PIN            0
`define WR_PIN            1
`define CS_PIN            2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DATA_DIR_RST      8'hFF
`define STROBE_DIR_RST    3'h7

// ------------------------------------------------------------
// Phase clock timing, four system clocks per instruction cycle
// ------------------------------------------------------------
`define PHASE_ONE         2'h0
`define PHASE_TWO         2'h1
`define PHASE_FOUR        2'h3

// ------------------------------------------------------------
// Bus answers
// ------------------------------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- inc/parallel_slave_byte_port_pkg.sv ----
`include "parallel_slave_byte_port_cfg.svh"

package parallel_slave_byte_port_pkg;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_DATA, SEL_STRB, SEL_FLAGS, SEL_CTRL, SEL_DIR, SEL_EN
  } reg_sel_type;

  typedef enum logic [1:0] {
    DONE_IDLE, DONE_WAIT_TWO, DONE_WAIT_FOUR
  } done_st_type;

  typedef struct packed {
    logic [1:0]            phase;
    logic [7:0]            data_meta;
    logic [7:0]            data_sync;
    logic [2:0]            strb_meta;
    logic [2:0]            strb_sync;
    logic [7:0]            data_snap;
    logic [2:0]            strb_snap;
    logic                  wr_seen;
    logic                  rd_seen;
    done_st_type           wr_done_st;
    done_st_type           rd_done_st;
    logic [7:0]            in_shadow;
    logic [7:0]            in_latch;
    logic [7:0]            out_latch;
    logic [7:0]            out_pend;
    logic                  out_pend_v;
    logic [2:0]            e_latch;
    logic [2:0]            e_pend;
    logic                  e_pend_v;
    logic [7:0]            data_dir;
    logic [2:0]            strb_dir;
    logic                  mode;
    logic                  input_full_flag;
    logic                  output_full_flag;
    logic                  input_overflow_flag;
    logic                  slave_irq_flag;
    logic                  slave_irq_en;
    logic                  aw_held;
    logic [7:0]            aw_idx;
    logic                  w_held;
    logic [7:0]            w_data;
    logic                  w_lane0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [7:0]            rdata;
    logic [1:0]            rresp;
  } port_state_type;

endpackage : parallel_slave_byte_port_pkg

// ---- logic/parallel_slave_byte_port.sv ----
// How it works
// RULE1: Mode bit set turns the data pins into an 8-bit slave data bus.
// RULE2: External processor reads and writes anytime, with no shared clock.
// RULE3: Mode reassigns three strobe pins as read, write, select inputs.
// RULE4: Two latches at one address: CPU writes outgoing, reads incoming.
// RULE5: In slave mode the data direction register is ignored.
// RULE6: External write starts when select and write are first both low.
// RULE7: Write end sets input-full and irq flag at phase four after phase two.
// RULE8: In slave mode only a CPU read of the data latch clears input-full.
// RULE9: Second write before CPU read sets the overflow flag.
// RULE10: Read start drives the outgoing latch and clears output-full at once.
// RULE11: Read end sets irq flag at phase four after next phase two.
// RULE12: Output-full stays clear until the CPU writes a new byte.
// RULE13: Outside slave mode both full flags are clear; overflow keeps value.
// RULE14: Irq flag latches until cleared; request only while enabled.
// RULE15: Port mode reads return pin levels, writes load the output latch.
// RULE16: Port writes land at cycle end; reads sample pins at cycle start.
// RULE17: Software should leave one instruction between port write and read.
// RULE18: All three strobes are active low, gated by select.
// RULE19: Strobes pass a two-stage synchroniser before any flag logic.
`include "parallel_slave_byte_port_cfg.svh"

module parallel_slave_byte_port
  import parallel_slave_byte_port_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   sys_rst_in,
  // AXI4-Lite write address and data
  input  wire logic                   s_axi_awvalid_in,
  output logic                        s_axi_awready_out,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                   s_axi_wvalid_in,
  output logic                        s_axi_wready_out,
  input  wire logic [`AXI_DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]             s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                        s_axi_bvalid_out,
  input  wire logic                   s_axi_bready_in,
  output logic [1:0]                  s_axi_bresp_out,
  // AXI4-Lite read
  input  wire logic                   s_axi_arvalid_in,
  output logic                        s_axi_arready_out,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr_in,
  output logic                        s_axi_rvalid_out,
  input  wire logic                   s_axi_rready_in,
  output logic [`AXI_DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  // Data pins
  input  wire logic [7:0]             data_pin_in,
  output logic [7:0]                  data_pin_out,
  output logic [7:0]                  data_pin_oe_out,
  // Strobe pins: bit 0 read, bit 1 write, bit 2 select
  input  wire logic [2:0]             strobe_pin_in,
  output logic [2:0]                  strobe_pin_out,
  output logic [2:0]                  strobe_pin_oe_out,
  // Interrupt
  output logic                        irq_out
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic reg_sel_type decode_sel(input logic [`AXI_ADDR_W-1:0] addr);
    reg_sel_type sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[9:2])
        `DATA_PORT_IDX:   sel = SEL_DATA;
        `STROBE_PORT_IDX: sel = SEL_STRB;
        `IRQ_FLAGS_IDX:   sel = SEL_FLAGS;
        `DATA_DIR_IDX:    sel = SEL_DIR;
        `CTRL_STATUS_IDX: sel = SEL_CTRL;
        `IRQ_ENABLES_IDX: sel = SEL_EN;
        default:          sel = SEL_NONE;
      endcase
    end
    if (addr[`AXI_ADDR_W-1:10] != '0)
    begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction : decode_sel

  function automatic done_st_type advance(input done_st_type st, input logic p2, input logic p4);
    done_st_type nx;
    nx = st;
    case (st)
      DONE_IDLE:      nx = DONE_IDLE;
      DONE_WAIT_TWO:  nx = p2 ? DONE_WAIT_FOUR : DONE_WAIT_TWO;
      DONE_WAIT_FOUR: nx = p4 ? DONE_IDLE : DONE_WAIT_FOUR;
      default:        nx = DONE_IDLE;
    endcase
    return nx;
  endfunction : advance

  port_state_type s_r;
  port_state_type s_nxt;

  logic        phase_two;
  logic        phase_four;
  logic        sel_wr;
  logic        sel_rd;
  logic        wr_done;
  logic        rd_done;
  logic        do_wr;
  logic        do_rd;
  logic        cpu_rd_clr;
  reg_sel_type wsel;
  reg_sel_type rsel;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.phase = 2'(s_r.phase + 2'h1);
    phase_two = (s_r.phase == `PHASE_TWO);
    phase_four = (s_r.phase == `PHASE_FOUR);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // RULE2 RULE19: two-stage sync
    s_nxt.data_meta = data_pin_in;
    s_nxt.data_sync = s_r.data_meta;
    s_nxt.strb_meta = strobe_pin_in;
    s_nxt.strb_sync = s_r.strb_meta;

    // RULE16: sample at cycle start
    if (s_r.phase == `PHASE_ONE)
    begin
      s_nxt.data_snap = s_r.data_sync;
      s_nxt.strb_snap = s_r.strb_sync;
    end

    // ------------------------------------------------------------
    // Strobe decoding and completion
    // ------------------------------------------------------------
    // RULE18: active-low strobes
    sel_wr = s_r.mode & ~s_r.strb_sync[`CS_PIN] & ~s_r.strb_sync[`WR_PIN];
    sel_rd = s_r.mode & ~s_r.strb_sync[`CS_PIN] & ~s_r.strb_sync[`RD_PIN];
    s_nxt.wr_seen = sel_wr;
    s_nxt.rd_seen = sel_rd;

    // RULE6: capture while both low
    if (sel_wr)
    begin
      s_nxt.in_shadow = s_r.data_sync;
    end

    // RULE7: write completion timing
    wr_done = (s_r.wr_done_st == DONE_WAIT_FOUR) && phase_four;
    s_nxt.wr_done_st = advance(s_r.wr_done_st, phase_two, phase_four);
    if (s_r.wr_seen && !sel_wr)
    begin
      s_nxt.wr_done_st = DONE_WAIT_TWO;
    end

    // RULE11: read completion timing
    rd_done = (s_r.rd_done_st == DONE_WAIT_FOUR) && phase_four;
    s_nxt.rd_done_st = advance(s_r.rd_done_st, phase_two, phase_four);
    if (s_r.rd_seen && !sel_rd)
    begin
      s_nxt.rd_done_st = DONE_WAIT_TWO;
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    // Write address and data are taken in either order.
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr_in[9:2];
      // Unmapped or misaligned addresses park on an unused index, so the write is refused.
      if (decode_sel(s_axi_awaddr_in) == SEL_NONE)
      begin
        s_nxt.aw_idx = `UNMAPPED_IDX;
      end
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata_in[7:0];
      s_nxt.w_lane0 = s_axi_wstrb_in[0];
    end
    if (s_r.bvalid && s_axi_bready_in)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready_in)
    begin
      s_nxt.rvalid = 1'b0;
    end

    do_wr = s_r.aw_held & s_r.w_held & ~s_r.bvalid;
    wsel = decode_sel({2'h0, s_r.aw_idx, 2'h0});
    do_rd = s_axi_arvalid_in & s_axi_arready_out;
    rsel = decode_sel(s_axi_araddr_in);
    cpu_rd_clr = do_rd && (rsel == SEL_DATA) && s_r.mode;

    if (do_wr)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      if (s_r.w_lane0)
      begin
        case (wsel)
          SEL_DATA:
          begin
            // RULE4: CPU write loads outgoing latch
            s_nxt.out_pend = s_r.w_data;
            s_nxt.out_pend_v = 1'b1;
          end
          SEL_STRB:
          begin
            s_nxt.e_pend = s_r.w_data[2:0];
            s_nxt.e_pend_v = 1'b1;
          end
          SEL_FLAGS:
          begin
            // RULE14: write one clears
            if (s_r.w_data[`SLAVE_IRQ_BIT])
            begin
              s_nxt.slave_irq_flag = 1'b0;
            end
          end
          SEL_DIR: s_nxt.data_dir = s_r.w_data;
          SEL_CTRL:
          begin
            s_nxt.input_overflow_flag = s_r.w_data[`INPUT_OVERFLOW_FLAG_BIT];
            s_nxt.mode = s_r.w_data[`MODE_BIT];
            s_nxt.strb_dir = s_r.w_data[2:0];
          end
          SEL_EN:   s_nxt.slave_irq_en = s_r.w_data[`SLAVE_IRQ_BIT];
          default:  s_nxt.bresp = `RESP_SLVERR;
        endcase
      end
    end

    if (do_rd)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `RESP_OKAY;
      case (rsel)
        // RULE15: port mode returns pins
        SEL_DATA:  s_nxt.rdata = s_r.mode ? s_r.in_latch : s_r.data_snap;
        SEL_STRB:  s_nxt.rdata = {5'h00, s_r.strb_snap};
        SEL_FLAGS: s_nxt.rdata = {s_r.slave_irq_flag, 7'h00};
        SEL_DIR:   s_nxt.rdata = s_r.data_dir;
        SEL_CTRL:  s_nxt.rdata = {s_r.input_full_flag, s_r.output_full_flag, s_r.input_overflow_flag, s_r.mode, 1'b0, s_r.strb_dir};
        SEL_EN:    s_nxt.rdata = {s_r.slave_irq_en, 7'h00};
        default:
        begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // RULE8: CPU read clears input-full
    if (cpu_rd_clr)
    begin
      s_nxt.input_full_flag = 1'b0;
    end

    // RULE10: read start clears output-full
    if (sel_rd && !s_r.rd_seen)
    begin
      s_nxt.output_full_flag = 1'b0;
    end

    // ------------------------------------------------------------
    // Deferred port writes
    // ------------------------------------------------------------
    // RULE16: port write lands at cycle end
    if (phase_four && s_r.out_pend_v)
    begin
      s_nxt.out_latch = s_r.out_pend;
      s_nxt.out_pend_v = 1'b0;
      // RULE12: only a CPU write sets output-full
      s_nxt.output_full_flag = 1'b1;
    end
    if (phase_four && s_r.e_pend_v)
    begin
      s_nxt.e_latch = s_r.e_pend;
      s_nxt.e_pend_v = 1'b0;
    end

    if (wr_done)
    begin
      s_nxt.in_latch = s_r.in_shadow;
      // RULE9: unread byte overrun
      if (s_r.input_full_flag && !cpu_rd_clr)
      begin
        s_nxt.input_overflow_flag = 1'b1;
      end
      s_nxt.input_full_flag = 1'b1;
      s_nxt.slave_irq_flag = 1'b1;
    end

    if (rd_done)
    begin
      s_nxt.slave_irq_flag = 1'b1;
    end

    // RULE13: full flags held clear outside mode
    if (!s_r.mode)
    begin
      s_nxt.input_full_flag = 1'b0;
      s_nxt.output_full_flag = 1'b0;
      s_nxt.wr_done_st = DONE_IDLE;
      s_nxt.rd_done_st = DONE_IDLE;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      s_r <= '0;
      s_r.data_dir <= `DATA_DIR_RST;
      s_r.strb_dir <= `STROBE_DIR_RST;
      s_r.strb_meta <= 3'h7;
      s_r.strb_sync <= 3'h7;
      s_r.wr_done_st <= DONE_IDLE;
      s_r.rd_done_st <= DONE_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign s_axi_awready_out = ~s_r.aw_held & ~s_r.bvalid;
  assign s_axi_wready_out  = ~s_r.w_held & ~s_r.bvalid;
  assign s_axi_bvalid_out  = s_r.bvalid;
  assign s_axi_bresp_out   = s_r.bresp;
  assign s_axi_arready_out = ~s_r.rvalid;
  assign s_axi_rvalid_out  = s_r.rvalid;
  assign s_axi_rdata_out   = {24'h00_0000, s_r.rdata};
  assign s_axi_rresp_out   = s_r.rresp;

  // RULE1: slave bus on data pins
  assign data_pin_out = s_r.out_latch;
  // RULE5: strobes steer the drivers
  assign data_pin_oe_out = s_r.mode ? {8{s_r.rd_seen}} : ~s_r.data_dir;

  // RULE3: strobe pins forced to inputs
  assign strobe_pin_out    = s_r.e_latch;
  assign strobe_pin_oe_out = s_r.mode ? 3'h0 : ~s_r.strb_dir;

  // ------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------
  // RULE14: gated interrupt request
  assign irq_out = s_r.slave_irq_flag & s_r.slave_irq_en;

endmodule : parallel_slave_byte_port

// ---- testbench/parallel_slave_byte_port_chk.sv ----
`include "parallel_slave_byte_port_cfg.svh"

module parallel_slave_byte_port_chk
(
  // Clock, reset and register bus
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  // Pins and interrupt
  input wire logic [2:0]  strobe_pin_in,
  input wire logic [2:0]  strobe_pin_oe_out,
  input wire logic [7:0]  data_pin_oe_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] aw_r;
  logic [7:0]  wd_r;
  logic        mode_r;
  logic        en_r;
  logic        busy_r;
  wire         rd_low = !strobe_pin_in[`CS_PIN] && !strobe_pin_in[`RD_PIN];

  // Mode and enable follow completed writes, so they lag the design slightly.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      mode_r <= 1'b0;
      en_r   <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_r   <= s_axi_awaddr_in;
        busy_r <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) wd_r <= s_axi_wdata_in[7:0];
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        busy_r <= 1'b0;
        if (aw_r == {2'b00, `CTRL_STATUS_IDX, 2'b00}) mode_r <= wd_r[`MODE_BIT];
        if (aw_r == {2'b00, `IRQ_ENABLES_IDX, 2'b00}) en_r <= wd_r[`SLAVE_IRQ_BIT];
      end
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  write_refuse_a:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while an answer is pending");
  read_answer_a:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  read_upper_a:
    assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");
  strobe_input_a:
    assert property (mode_r |-> strobe_pin_oe_out == 3'h0)
    else $error("strobe pin driven in slave mode");
  dir_ignored_a:
    assert property ((mode_r && !rd_low) [*5] |-> data_pin_oe_out == 8'h00)
    else $error("data pins driven without a read");
  read_drive_a:
    assert property ((mode_r && rd_low) [*5] |-> data_pin_oe_out == 8'hff)
    else $error("data pins not driven during a read");
  irq_mask_a:
    assert property ($fell(en_r) |-> !irq_out)
    else $error("interrupt high while disabled");
  irq_sticky_a:
    assert property (irq_out && !busy_r |=> irq_out)
    else $error("interrupt dropped without a write");
endmodule : parallel_slave_byte_port_chk

bind parallel_slave_byte_port parallel_slave_byte_port_chk parallel_slave_byte_port_chk_inst
(
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_wdata_in(s_axi_wdata_in), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rdata_out(s_axi_rdata_out), .strobe_pin_in(strobe_pin_in),
  .strobe_pin_oe_out(strobe_pin_oe_out), .data_pin_oe_out(data_pin_oe_out), .irq_out(irq_out)
);

// ---- testbench/ext_cpu_model.sv ----
module ext_cpu_model
(
  // Pacing clock
  input  wire logic       clock_in,
  // Wire levels and drives
  input  wire logic [7:0] bus_in,
  output logic [2:0]      strobe_n_out,
  output logic [7:0]      data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    strobe_n_out = 3'h7;
    data_out = 8'h5a;
  end
  task automatic wr_byte(input logic [7:0] b, input int len);
    @(posedge clock_in);
    data_out <= b;
    strobe_n_out <= 3'b001;
    repeat (len) @(posedge clock_in);
    strobe_n_out <= 3'h7;
    @(posedge clock_in);
    data_out <= ~b;
  endtask : wr_byte
  task automatic rd_byte(input int len, output logic [7:0] b);
    @(posedge clock_in);
    strobe_n_out <= 3'b010;
    repeat (len) @(posedge clock_in);
    b = bus_in;
    strobe_n_out <= 3'h7;
  endtask : rd_byte
  task automatic drive(input logic [7:0] b);
    @(posedge clock_in);
    data_out <= b;
  endtask : drive
endmodule : ext_cpu_model

// ---- testbench/parallel_slave_byte_port_test.sv ----
`include "parallel_slave_byte_port_cfg.svh"

module parallel_slave_byte_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] a_data  = {2'b00, `DATA_PORT_IDX, 2'b00};
  localparam logic [11:0] a_strb  = {2'b00, `STROBE_PORT_IDX, 2'b00};
  localparam logic [11:0] a_flags = {2'b00, `IRQ_FLAGS_IDX, 2'b00};
  localparam logic [11:0] a_dir   = {2'b00, `DATA_DIR_IDX, 2'b00};
  localparam logic [11:0] a_ctrl  = {2'b00, `CTRL_STATUS_IDX, 2'b00};
  localparam logic [11:0] a_en    = {2'b00, `IRQ_ENABLES_IDX, 2'b00};
  logic        clk, rst, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  br, rr, resp;
  logic [7:0]  pin_o, pin_oe, ext_d, bus, rd_v, b, c, e;
  logic [2:0]  stb, stb_w, s_o, s_oe;
  int          n_fail, checks_done, seed, i;

  assign bus = (pin_o & pin_oe) | (ext_d & ~pin_oe);
  assign stb_w = (s_o & s_oe) | (stb & ~s_oe);

  parallel_slave_byte_port parallel_slave_byte_port_inst
  (
    .clock_in(clk), .sys_rst_in(rst), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .data_pin_in(bus), .data_pin_out(pin_o),
    .data_pin_oe_out(pin_oe), .strobe_pin_in(stb_w), .strobe_pin_out(s_o), .strobe_pin_oe_out(s_oe), .irq_out(irq)
  );
  ext_cpu_model ext_cpu_model_inst
  (
    .clock_in(clk), .bus_in(bus), .strobe_n_out(stb), .data_out(ext_d)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] ctrl_exp(input logic f_in, f_out, f_ov, f_mode);
    return {f_in, f_out, f_ov, f_mode, 4'h7};
  endfunction : ctrl_exp

  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x)
    begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      n_fail++;
    end
  endtask : chk

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv)
      begin
        resp = br;
        bry <= 1'b0;
        return;
      end
    end
    chk("write answer", 8'h01, 8'h00);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv)
      begin
        rd_v = rdat[7:0];
        resp = rr;
        rry <= 1'b0;
        return;
      end
    end
    chk("read answer", 8'h01, 8'h00);
  endtask : axi_rd

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] x);
    axi_rd(a);
    chk(nm, x, rd_v);
  endtask : rd_chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial
  begin
    #400_000;
    n_fail++;
    end_of_test();
  end

  initial
  begin
    {awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    seed = 32'h0000_3e4d;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl reset", a_ctrl, ctrl_exp(0, 0, 0, 0));
    rd_chk("flags reset", a_flags, 8'h00);
    rd_chk("enables reset", a_en, 8'h00);
    rd_chk("dir reset", a_dir, 8'hff);
    rd_chk("unmapped", 12'h004, 8'h00);
    chk("unmapped resp", {6'h00, `RESP_SLVERR}, {6'h00, resp});
    axi_wr(12'h021, 8'hff);
    chk("misaligned resp", {6'h00, `RESP_SLVERR}, {6'h00, resp});
    $display("reset test done");
    b = 8'($random(seed));
    e = 8'($random(seed));
    axi_wr(a_dir, 8'hf0);
    ext_cpu_model_inst.drive(e);
    axi_wr(a_data, b);
    repeat (8) @(posedge clk);
    chk("port latch", b, pin_o);
    rd_chk("port pins", a_data, {e[7:4], b[3:0]});
    axi_wr(a_data, rd_v ^ 8'h81);
    repeat (4) @(posedge clk);
    chk("rmw latch", {e[7:4], b[3:0]} ^ 8'h81, pin_o);
    $display("port test done");
    axi_wr(a_dir, 8'h00);
    axi_wr(a_ctrl, 8'h17);
    repeat (2) @(posedge clk);
    chk("slave oe", 8'h00, pin_oe);
    for (i = 0; i < 4; i++)
    begin
      b = 8'($random(seed));
      ext_cpu_model_inst.wr_byte(b, 3 + i);
      repeat (12) @(posedge clk);
      rd_chk("ibf set", a_ctrl, ctrl_exp(1, 0, 0, 1));
      rd_chk("flag set", a_flags, 8'h80);
      chk("irq masked", 8'h00, {7'h00, irq});
      rd_chk("in latch", a_data, b);
      rd_chk("ibf clear", a_ctrl, ctrl_exp(0, 0, 0, 1));
      axi_wr(a_flags, 8'h80);
    end
    rd_chk("flag clear", a_flags, 8'h00);
    ext_cpu_model_inst.wr_byte(8'($random(seed)), 3);
    c = 8'($random(seed));
    ext_cpu_model_inst.wr_byte(c, 6);
    repeat (12) @(posedge clk);
    rd_chk("overflow", a_ctrl, ctrl_exp(1, 0, 1, 1));
    axi_wr(a_ctrl, 8'h37);
    rd_chk("ibf kept", a_ctrl, ctrl_exp(1, 0, 1, 1));
    rd_chk("newer byte", a_data, c);
    $display("write test done");
    axi_wr(a_en, 8'h80);
    axi_wr(a_flags, 8'h80);
    b = 8'($random(seed));
    axi_wr(a_data, b);
    repeat (4) @(posedge clk);
    rd_chk("obf set", a_ctrl, ctrl_exp(0, 1, 1, 1));
    chk("irq idle", 8'h00, {7'h00, irq});
    ext_cpu_model_inst.rd_byte(5, c);
    chk("ext read", b, c);
    rd_chk("obf clear", a_ctrl, ctrl_exp(0, 0, 1, 1));
    repeat (12) @(posedge clk);
    chk("read irq", 8'h01, {7'h00, irq});
    axi_wr(a_en, 8'h00);
    chk("irq off", 8'h00, {7'h00, irq});
    axi_wr(a_en, 8'h80);
    chk("irq sticky", 8'h01, {7'h00, irq});
    rd_chk("obf stays", a_ctrl, ctrl_exp(0, 0, 1, 1));
    axi_wr(a_flags, 8'h80);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("read test done");
    ext_cpu_model_inst.wr_byte(8'($random(seed)), 4);
    axi_wr(a_data, 8'h3c);
    repeat (12) @(posedge clk);
    rd_chk("both full", a_ctrl, ctrl_exp(1, 1, 1, 1));
    axi_wr(a_dir, 8'hff);
    axi_wr(a_ctrl, 8'h27);
    rd_chk("mode off", a_ctrl, ctrl_exp(0, 0, 1, 0));
    axi_wr(a_ctrl, 8'h07);
    rd_chk("input_overflow_flag cleared", a_ctrl, ctrl_exp(0, 0, 0, 0));
    axi_wr(a_ctrl, 8'h00);
    b = 8'($random(seed));
    axi_wr(a_strb, b);
    repeat (8) @(posedge clk);
    chk("strobe latch", {5'h00, b[2:0]}, {5'h00, s_o});
    rd_chk("strobe pins", a_strb, {5'h00, b[2:0]});
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl re-reset", a_ctrl, ctrl_exp(0, 0, 0, 0));
    $display("mode test done");
    end_of_test();
  end
endmodule : parallel_slave_byte_port_test
